// ===== pkg/akc_defines.svh
`ifndef AKC_DEFINES_SVH
`define AKC_DEFINES_SVH
`define AKC_OFF_CTRL     8'h00
`define AKC_OFF_SRST     8'h14
`define AKC_OFF_FRAME    8'h18
`define AKC_OFF_HI_A     8'h1C
`define AKC_OFF_INS_LO   8'h20
`define AKC_OFF_PAR_LO   8'h24
`define AKC_OFF_HI_B     8'h28
`define AKC_OFF_IN_LO    8'h2C
`define AKC_OFF_OUT_LO   8'h30
`define AKC_OFF_IN_STEP  8'h64
`define AKC_OFF_OUT_STEP 8'h68
`define AKC_BIT_LAUNCH   0
`define AKC_BIT_COMPLETE 1
`define AKC_BIT_QUIET    2
`define AKC_BIT_CONSUMED 3
`define AKC_BIT_AUTO     7
`define AKC_BIT_SRST     0
`define AKC_RESP_OKAY    2'h0
`define AKC_RESP_SLVERR  2'h2
`define AKC_RST_WORD     32'h0000_0000
`define AKC_INSTR_STEP   64'h0000_0000_0000_0008
`endif

// ===== pkg/akc_pkg.sv
`default_nettype none
package akc_pkg;
  typedef enum logic [3:0] {
    S_IDLE  = 4'h1,
    S_FETCH = 4'h2,
    S_DISP  = 4'h4,
    S_DRAIN = 4'h8
  } akc_sch_state_t;

  typedef struct packed {
    akc_sch_state_t state;
    logic [63:0]    addr;
    logic [31:0]    instr;
    logic           fetch_req;
    logic           disp_valid;
    logic           last;
    logic           consumed;
    logic           done;
    logic           quiet;
  } akc_sch_t;

  typedef struct packed {
    logic        wrdy;
    logic        rrdy;
    logic        bvalid;
    logic        rvalid;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        launch;
    logic        complete;
    logic        consumed;
    logic        auto_rs;
    logic        krst;
    logic [31:0] frame;
    logic [31:0] hi_a;
    logic [31:0] ins_lo;
    logic [31:0] par_lo;
    logic [31:0] hi_b;
    logic [31:0] in_lo;
    logic [31:0] out_lo;
    logic [31:0] in_step;
    logic [31:0] out_step;
  } akc_regs_t;
endpackage : akc_pkg
`default_nettype wire

// ===== design/akc_sched.sv
`include "akc_defines.svh"
`default_nettype none
module akc_sched (
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_ce,
  input  wire logic        i_srst,
  input  wire logic        i_go,
  input  wire logic [63:0] i_base,
  output logic             o_fetch_req,
  output logic [63:0]      o_fetch_addr,
  input  wire logic        i_fetch_ack,
  input  wire logic [31:0] i_fetch_data,
  input  wire logic        i_fetch_last,
  output logic             o_disp_valid,
  output logic [31:0]      o_disp_instr,
  input  wire logic        i_disp_ready,
  input  wire logic        i_units_idle,
  output logic             o_consumed,
  output logic             o_done,
  output logic             o_quiet
);
  localparam akc_pkg::akc_sch_t SCH_RST = '{
    state: akc_pkg::S_IDLE, addr: 64'h0, instr: 32'h0, fetch_req: 1'b0,
    disp_valid: 1'b0, last: 1'b0, consumed: 1'b0, done: 1'b0,
    quiet: 1'b1};

  akc_pkg::akc_sch_t s_r;
  akc_pkg::akc_sch_t s_nxt;

  always_comb begin
    s_nxt          = s_r;
    s_nxt.consumed = 1'b0;
    s_nxt.done     = 1'b0;
    if (i_srst) begin
      s_nxt = SCH_RST;
    end else begin
      case (s_r.state)
        akc_pkg::S_IDLE: begin
          if (i_go) begin
            s_nxt.state     = akc_pkg::S_FETCH;
            s_nxt.addr      = i_base;
            s_nxt.fetch_req = 1'b1;
            s_nxt.quiet     = 1'b0;
          end
        end
        akc_pkg::S_FETCH: begin
          if (i_fetch_ack) begin
            s_nxt.fetch_req  = 1'b0;
            s_nxt.instr      = i_fetch_data;
            s_nxt.last       = i_fetch_last;
            s_nxt.disp_valid = 1'b1;
            s_nxt.state      = akc_pkg::S_DISP;
          end
        end
        akc_pkg::S_DISP: begin
          // unit ready stands for its dependencies being met
          if (i_disp_ready) begin
            s_nxt.disp_valid = 1'b0;
            if (s_r.last) begin
              s_nxt.consumed = 1'b1;
              s_nxt.state    = akc_pkg::S_DRAIN;
            end else begin
              s_nxt.addr      = s_r.addr + `AKC_INSTR_STEP;
              s_nxt.fetch_req = 1'b1;
              s_nxt.state     = akc_pkg::S_FETCH;
            end
          end
        end
        akc_pkg::S_DRAIN: begin
          if (i_units_idle) begin
            s_nxt.done  = 1'b1;
            s_nxt.quiet = 1'b1;
            s_nxt.state = akc_pkg::S_IDLE;
          end
        end
        default: s_nxt = SCH_RST;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_r <= SCH_RST;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  assign o_fetch_req  = s_r.fetch_req;
  assign o_fetch_addr = s_r.addr;
  assign o_disp_valid = s_r.disp_valid;
  assign o_disp_instr = s_r.instr;
  assign o_consumed   = s_r.consumed;
  assign o_done       = s_r.done;
  assign o_quiet      = s_r.quiet;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  a_fetch_base: assert property (
    i_ce && s_r.state == akc_pkg::S_IDLE && i_go && !i_srst
    |=> o_fetch_req && o_fetch_addr == $past(i_base))
    else $error("fetch did not start at base");
endmodule : akc_sched
`default_nettype wire

// ===== design/akc_ctrl_regs.sv
`include "akc_defines.svh"
`default_nettype none
module akc_ctrl_regs #(
  parameter bit BATCH_EN = 1'b1
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_ce,
  input  wire logic        i_s_awvalid,
  output logic             o_s_awready,
  input  wire logic [7:0]  i_s_awaddr,
  input  wire logic        i_s_wvalid,
  output logic             o_s_wready,
  input  wire logic [31:0] i_s_wdata,
  input  wire logic [3:0]  i_s_wstrb,
  output logic             o_s_bvalid,
  input  wire logic        i_s_bready,
  output logic [1:0]       o_s_bresp,
  input  wire logic        i_s_arvalid,
  output logic             o_s_arready,
  input  wire logic [7:0]  i_s_araddr,
  output logic             o_s_rvalid,
  input  wire logic        i_s_rready,
  output logic [31:0]      o_s_rdata,
  output logic [1:0]       o_s_rresp,
  output logic             o_fetch_req,
  output logic [63:0]      o_fetch_addr,
  input  wire logic        i_fetch_ack,
  input  wire logic [31:0] i_fetch_data,
  input  wire logic        i_fetch_last,
  output logic             o_disp_valid,
  output logic [31:0]      o_disp_instr,
  input  wire logic        i_disp_ready,
  input  wire logic        i_units_idle,
  output logic             o_kernel_rst,
  output logic [31:0]      o_frame_count,
  output logic [63:0]      o_param_addr,
  output logic [63:0]      o_in_addr,
  output logic [63:0]      o_out_addr,
  output logic [31:0]      o_in_step,
  output logic [31:0]      o_out_step
);
  localparam akc_pkg::akc_regs_t REG_RST = '{
    wrdy: 1'b0, rrdy: 1'b0, bvalid: 1'b0, rvalid: 1'b0,
    bresp: `AKC_RESP_OKAY, rresp: `AKC_RESP_OKAY, rdata: `AKC_RST_WORD,
    launch: 1'b0, complete: 1'b0, consumed: 1'b0, auto_rs: 1'b0,
    krst: 1'b0, frame: `AKC_RST_WORD, hi_a: `AKC_RST_WORD,
    ins_lo: `AKC_RST_WORD, par_lo: `AKC_RST_WORD, hi_b: `AKC_RST_WORD,
    in_lo: `AKC_RST_WORD, out_lo: `AKC_RST_WORD,
    in_step: `AKC_RST_WORD, out_step: `AKC_RST_WORD};

  akc_pkg::akc_regs_t r_r;
  akc_pkg::akc_regs_t r_nxt;

  logic        wr_go;
  logic        rd_go;
  logic [7:0]  wa;
  logic [7:0]  ra;
  logic        sc_consumed;
  logic        sc_done;
  logic        sc_quiet;
  logic [31:0] ctrl_word;
  logic        set_launch;

  function automatic logic [31:0] akc_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : akc_merge

  // word-aligned decode; low address bits do not select anything
  assign wa = {i_s_awaddr[7:2], 2'b00};
  assign ra = {i_s_araddr[7:2], 2'b00};

  // valids must hold once raised, so the one-cycle ready is safe
  assign wr_go = r_r.wrdy & i_s_awvalid & i_s_wvalid;
  assign rd_go = r_r.rrdy & i_s_arvalid;

  assign set_launch = wr_go && wa == `AKC_OFF_CTRL &&
                      i_s_wstrb[0] && i_s_wdata[`AKC_BIT_LAUNCH];

  always_comb begin
    ctrl_word                    = 32'h0000_0000;
    ctrl_word[`AKC_BIT_LAUNCH]   = r_r.launch;
    ctrl_word[`AKC_BIT_COMPLETE] = r_r.complete;
    ctrl_word[`AKC_BIT_QUIET]    = sc_quiet;
    ctrl_word[`AKC_BIT_CONSUMED] = r_r.consumed;
    ctrl_word[`AKC_BIT_AUTO]     = r_r.auto_rs;
  end

  always_comb begin
    r_nxt          = r_r;
    r_nxt.wrdy     = 1'b0;
    r_nxt.rrdy     = 1'b0;
    r_nxt.krst     = 1'b0;
    r_nxt.consumed = sc_consumed;
    if (!r_r.wrdy && !r_r.bvalid && i_s_awvalid && i_s_wvalid) begin
      r_nxt.wrdy = 1'b1;
    end
    if (!r_r.rrdy && !r_r.rvalid && i_s_arvalid) begin
      r_nxt.rrdy = 1'b1;
    end
    if (r_r.bvalid && i_s_bready) begin
      r_nxt.bvalid = 1'b0;
    end
    if (r_r.rvalid && i_s_rready) begin
      r_nxt.rvalid = 1'b0;
    end
    // auto restart keeps launch up across the handshake
    if (sc_consumed && !r_r.auto_rs) begin
      r_nxt.launch = 1'b0;
    end
    if (rd_go && ra == `AKC_OFF_CTRL) begin
      r_nxt.complete = 1'b0;
    end
    if (wr_go) begin
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp  = `AKC_RESP_OKAY;
      case (wa)
        `AKC_OFF_CTRL: begin
          // bits 1..6 and upper bytes are not writable
          if (i_s_wstrb[0]) begin
            r_nxt.auto_rs = i_s_wdata[`AKC_BIT_AUTO];
          end
        end
        `AKC_OFF_SRST: begin
          if (i_s_wstrb[0] && i_s_wdata[`AKC_BIT_SRST]) begin
            r_nxt.krst = 1'b1;
          end
        end
        `AKC_OFF_FRAME: begin
          r_nxt.frame = akc_merge(r_r.frame, i_s_wdata, i_s_wstrb);
        end
        `AKC_OFF_HI_A: begin
          r_nxt.hi_a = akc_merge(r_r.hi_a, i_s_wdata, i_s_wstrb);
        end
        `AKC_OFF_INS_LO: begin
          r_nxt.ins_lo = akc_merge(r_r.ins_lo, i_s_wdata, i_s_wstrb);
        end
        `AKC_OFF_PAR_LO: begin
          r_nxt.par_lo = akc_merge(r_r.par_lo, i_s_wdata, i_s_wstrb);
        end
        `AKC_OFF_HI_B: begin
          r_nxt.hi_b = akc_merge(r_r.hi_b, i_s_wdata, i_s_wstrb);
        end
        `AKC_OFF_IN_LO: begin
          r_nxt.in_lo = akc_merge(r_r.in_lo, i_s_wdata, i_s_wstrb);
        end
        `AKC_OFF_OUT_LO: begin
          r_nxt.out_lo = akc_merge(r_r.out_lo, i_s_wdata, i_s_wstrb);
        end
        `AKC_OFF_IN_STEP: begin
          if (BATCH_EN) begin
            r_nxt.in_step = akc_merge(r_r.in_step, i_s_wdata,
                                      i_s_wstrb);
          end else begin
            r_nxt.bresp = `AKC_RESP_SLVERR;
          end
        end
        `AKC_OFF_OUT_STEP: begin
          if (BATCH_EN) begin
            r_nxt.out_step = akc_merge(r_r.out_step, i_s_wdata,
                                       i_s_wstrb);
          end else begin
            r_nxt.bresp = `AKC_RESP_SLVERR;
          end
        end
        default: r_nxt.bresp = `AKC_RESP_SLVERR;
      endcase
    end
    if (set_launch) begin
      r_nxt.launch = 1'b1;
    end
    // a finish in the same cycle as the clearing read is kept
    if (sc_done) begin
      r_nxt.complete = 1'b1;
    end
    // soft reset wins over every handshake bit
    if (r_r.krst) begin
      r_nxt.launch   = 1'b0;
      r_nxt.complete = 1'b0;
      r_nxt.consumed = 1'b0;
    end
    if (rd_go) begin
      r_nxt.rvalid = 1'b1;
      r_nxt.rresp  = `AKC_RESP_OKAY;
      r_nxt.rdata  = `AKC_RST_WORD;
      case (ra)
        `AKC_OFF_CTRL:   r_nxt.rdata = ctrl_word;
        `AKC_OFF_SRST:   r_nxt.rdata = `AKC_RST_WORD;
        `AKC_OFF_FRAME:  r_nxt.rdata = r_r.frame;
        `AKC_OFF_HI_A:   r_nxt.rdata = r_r.hi_a;
        `AKC_OFF_INS_LO: r_nxt.rdata = r_r.ins_lo;
        `AKC_OFF_PAR_LO: r_nxt.rdata = r_r.par_lo;
        `AKC_OFF_HI_B:   r_nxt.rdata = r_r.hi_b;
        `AKC_OFF_IN_LO:  r_nxt.rdata = r_r.in_lo;
        `AKC_OFF_OUT_LO: r_nxt.rdata = r_r.out_lo;
        `AKC_OFF_IN_STEP: begin
          if (BATCH_EN) begin
            r_nxt.rdata = r_r.in_step;
          end else begin
            r_nxt.rresp = `AKC_RESP_SLVERR;
          end
        end
        `AKC_OFF_OUT_STEP: begin
          if (BATCH_EN) begin
            r_nxt.rdata = r_r.out_step;
          end else begin
            r_nxt.rresp = `AKC_RESP_SLVERR;
          end
        end
        default: r_nxt.rresp = `AKC_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r_r <= REG_RST;
    end else if (i_ce) begin
      r_r <= r_nxt;
    end
  end

  akc_sched u_sched (
    .i_sys_clk    (i_sys_clk),
    .i_resetn     (i_resetn),
    .i_ce         (i_ce),
    .i_srst       (r_r.krst),
    .i_go         (r_r.launch),
    .i_base       ({r_r.hi_a, r_r.ins_lo}),
    .o_fetch_req  (o_fetch_req),
    .o_fetch_addr (o_fetch_addr),
    .i_fetch_ack  (i_fetch_ack),
    .i_fetch_data (i_fetch_data),
    .i_fetch_last (i_fetch_last),
    .o_disp_valid (o_disp_valid),
    .o_disp_instr (o_disp_instr),
    .i_disp_ready (i_disp_ready),
    .i_units_idle (i_units_idle),
    .o_consumed   (sc_consumed),
    .o_done       (sc_done),
    .o_quiet      (sc_quiet)
  );

  assign o_s_awready   = r_r.wrdy;
  assign o_s_wready    = r_r.wrdy;
  assign o_s_bvalid    = r_r.bvalid;
  assign o_s_bresp     = r_r.bresp;
  assign o_s_arready   = r_r.rrdy;
  assign o_s_rvalid    = r_r.rvalid;
  assign o_s_rdata     = r_r.rdata;
  assign o_s_rresp     = r_r.rresp;
  assign o_kernel_rst  = r_r.krst;
  assign o_frame_count = r_r.frame;
  assign o_param_addr  = {r_r.hi_a, r_r.par_lo};
  assign o_in_addr     = {r_r.hi_b, r_r.in_lo};
  assign o_out_addr    = {r_r.hi_b, r_r.out_lo};
  assign o_in_step     = r_r.in_step;
  assign o_out_step    = r_r.out_step;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  a_write_answer: assert property (
    i_ce && wr_go |=> o_s_bvalid && !o_s_awready)
    else $error("write not answered");

  a_launch_set: assert property (
    i_ce && set_launch && !r_r.krst |=> r_r.launch)
    else $error("launch not set by write");

  a_launch_clr: assert property (
    i_ce && sc_consumed && !r_r.auto_rs && !set_launch
    |=> !r_r.launch)
    else $error("launch not cleared on handshake");

  a_auto_hold: assert property (
    i_ce && r_r.launch && r_r.auto_rs && !r_r.krst |=> r_r.launch)
    else $error("auto restart dropped launch");

  a_complete_set: assert property (
    i_ce && sc_done && !r_r.krst |=> r_r.complete)
    else $error("complete not set");

  a_complete_rdclr: assert property (
    i_ce && rd_go && ra == `AKC_OFF_CTRL && !sc_done
    |=> !r_r.complete)
    else $error("complete not cleared by read");

  a_ctrl_read: assert property (
    i_ce && rd_go && ra == `AKC_OFF_CTRL
    |=> o_s_rdata[`AKC_BIT_QUIET] == $past(sc_quiet)
        && o_s_rdata[31:8] == 24'h00_0000
        && o_s_rdata[6:4] == 3'h0)
    else $error("control read word wrong");

  // a stretched scheduler pulse would show up here as a second cycle
  a_consumed_pulse: assert property (
    i_ce && r_r.consumed |=> !r_r.consumed)
    else $error("consumed bit did not self clear");

  a_soft_rst: assert property (
    i_ce && wr_go && wa == `AKC_OFF_SRST && i_s_wstrb[0]
    && i_s_wdata[`AKC_BIT_SRST]
    |=> o_kernel_rst ##1 (!i_ce || (!r_r.launch && !o_fetch_req)))
    else $error("soft reset not applied");

  a_frame_write: assert property (
    i_ce && wr_go && wa == `AKC_OFF_FRAME && i_s_wstrb == 4'hF
    |=> o_frame_count == $past(i_s_wdata))
    else $error("sequence length not stored");

  a_batch_absent: assert property (
    i_ce && rd_go
    && (ra == `AKC_OFF_IN_STEP || ra == `AKC_OFF_OUT_STEP)
    |=> o_s_rresp == (BATCH_EN ? `AKC_RESP_OKAY : `AKC_RESP_SLVERR))
    else $error("step register answer wrong for variant");
endmodule : akc_ctrl_regs
`default_nettype wire

// ===== testbench/akc_mem_model.sv
`default_nettype none
// memory and compute-unit side of the kernel: answers fetches with a word
// derived from the address, alternating prompt and slow replies
module akc_mem_model #(
  parameter int NW = 3
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_krst,
  input  wire logic        i_fetch_req,
  input  wire logic [63:0] i_fetch_addr,
  output logic             o_fetch_ack,
  output logic [31:0]      o_fetch_data,
  output logic             o_fetch_last,
  input  wire logic        i_disp_valid,
  output logic             o_disp_ready,
  output logic             o_units_idle
);
  timeunit 1ns;
  timeprecision 1ps;
  int k;
  int gap;
  int tail;
  bit slow;
  bit lastd;
  // soft reset clears the model too, or a stale ack lands on an idle kernel
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn || i_krst) begin
      o_fetch_ack  <= 1'b0;
      o_fetch_data <= 32'h0000_0000;
      o_fetch_last <= 1'b0;
      o_disp_ready <= 1'b0;
      o_units_idle <= 1'b1;
      k            <= 0;
      gap          <= 0;
      tail         <= 0;
      slow         <= 1'b0;
      lastd        <= 1'b0;
    end else begin
      o_fetch_ack  <= 1'b0;
      // released data bus flips every cycle, never holding the last word two cycles running
      o_fetch_data <= ~o_fetch_data;
      o_disp_ready <= i_disp_valid && !o_disp_ready;
      if (i_fetch_req && !o_fetch_ack) begin
        o_units_idle <= 1'b0;
        if (gap == 0) begin
          o_fetch_ack  <= 1'b1;
          o_fetch_data <= i_fetch_addr[31:0] + 32'h0000_0001;
          o_fetch_last <= (k == NW - 1);
          lastd        <= (k == NW - 1);
          k            <= (k == NW - 1) ? 0 : k + 1;
          slow         <= !slow;
          gap          <= slow ? 0 : 3;
        end else begin
          gap <= gap - 1;
        end
      end
      if (i_disp_valid && o_disp_ready && lastd) begin
        tail <= 6;
      end else if (tail > 0) begin
        tail <= tail - 1;
      end
      if (tail == 1) begin
        o_units_idle <= 1'b1;
      end
    end
  end
endmodule : akc_mem_model
`default_nettype wire

// ===== testbench/testbench.sv
`include "akc_defines.svh"
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  bad_count++; $display("[ERR] %s exp %h got %h", nm, (e), (g)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] OFFS [9] = '{`AKC_OFF_FRAME, `AKC_OFF_HI_A,
    `AKC_OFF_INS_LO, `AKC_OFF_PAR_LO, `AKC_OFF_HI_B, `AKC_OFF_IN_LO,
    `AKC_OFF_OUT_LO, `AKC_OFF_IN_STEP, `AKC_OFF_OUT_STEP};
  logic i_sys_clk = 1'b0, i_resetn = 1'b0, i_ce = 1'b1;
  logic i_s_awvalid = 1'b0, i_s_wvalid = 1'b0, i_s_arvalid = 1'b0;
  logic i_s_bready = 1'b0, i_s_rready = 1'b0;
  logic [7:0] i_s_awaddr = 8'h00, i_s_araddr = 8'h00;
  logic [31:0] i_s_wdata = 32'h0000_0000;
  logic [3:0] i_s_wstrb = 4'h0;
  logic o_s_awready, o_s_wready, o_s_bvalid, o_s_arready, o_s_rvalid;
  logic [1:0] o_s_bresp, o_s_rresp;
  logic [31:0] o_s_rdata, i_fetch_data, o_disp_instr, o_frame_count;
  logic o_fetch_req, i_fetch_ack, i_fetch_last, o_disp_valid;
  logic i_disp_ready, i_units_idle, o_kernel_rst;
  logic [63:0] o_fetch_addr, o_param_addr, o_in_addr, o_out_addr, base;
  logic [31:0] o_in_step, o_out_step, d, ins, v [9];
  logic [34:0] rq [$];
  logic [34:0] e35;
  logic [1:0] bq [$];
  logic [1:0] e2;
  logic [31:0] iq [$];
  int bad_count = 0, comparisons = 0, k = 0, krst_n = 0, n0;
  integer seed = 32'h0da6;

  akc_ctrl_regs #(.BATCH_EN(1'b1)) uut (
    .i_sys_clk, .i_resetn, .i_ce, .i_s_awvalid, .o_s_awready, .i_s_awaddr,
    .i_s_wvalid, .o_s_wready, .i_s_wdata, .i_s_wstrb, .o_s_bvalid,
    .i_s_bready, .o_s_bresp, .i_s_arvalid, .o_s_arready, .i_s_araddr,
    .o_s_rvalid, .i_s_rready, .o_s_rdata, .o_s_rresp, .o_fetch_req,
    .o_fetch_addr, .i_fetch_ack, .i_fetch_data, .i_fetch_last,
    .o_disp_valid, .o_disp_instr, .i_disp_ready, .i_units_idle,
    .o_kernel_rst, .o_frame_count, .o_param_addr, .o_in_addr, .o_out_addr,
    .o_in_step, .o_out_step);

  akc_mem_model #(.NW(3)) mem (
    .i_sys_clk, .i_resetn, .i_krst(o_kernel_rst), .i_fetch_req(o_fetch_req),
    .i_fetch_addr(o_fetch_addr), .o_fetch_ack(i_fetch_ack),
    .o_fetch_data(i_fetch_data), .o_fetch_last(i_fetch_last),
    .i_disp_valid(o_disp_valid), .o_disp_ready(i_disp_ready),
    .o_units_idle(i_units_idle));

  always #25 i_sys_clk = ~i_sys_clk;

  // response readiness stalls at random to exercise held responses
  always @(posedge i_sys_clk) begin
    i_s_rready <= 1'($random(seed));
    i_s_bready <= 1'($random(seed));
  end

  always @(negedge i_sys_clk) begin
    if (o_s_rvalid && i_s_rready) begin
      e35 = rq.pop_front();
      if (e35[34]) `CHK("read", e35[33:0], {o_s_rresp, o_s_rdata})
    end
    if (o_s_bvalid && i_s_bready) begin
      e2 = bq.pop_front();
      `CHK("bresp", e2, o_s_bresp)
    end
    if (o_fetch_req && i_fetch_ack) begin
      `CHK("fetch addr", base + 64'(k) * `AKC_INSTR_STEP, o_fetch_addr)
      iq.push_back(o_fetch_addr[31:0] + 32'h0000_0001);
      k = i_fetch_last ? 0 : k + 1;
    end
    if (o_disp_valid && i_disp_ready) begin
      ins = iq.pop_front();
      `CHK("dispatch", ins, o_disp_instr)
    end
    if (o_kernel_rst) begin
      krst_n++;
      k = 0;
      iq.delete();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] w,
                    input logic [3:0] s, input logic [1:0] resp);
    int n;
    @(posedge i_sys_clk);
    i_s_awvalid <= 1'b1;
    i_s_wvalid  <= 1'b1;
    i_s_awaddr  <= a;
    i_s_wdata   <= w;
    i_s_wstrb   <= s;
    bq.push_back(resp);
    @(negedge i_sys_clk);
    for (n = 0; n < 64 && !o_s_awready; n++) @(negedge i_sys_clk);
    `CHK("wready", 1'b1, o_s_wready)
    @(posedge i_sys_clk);
    i_s_awvalid <= 1'b0;
    i_s_wvalid  <= 1'b0;
    @(negedge i_sys_clk);
    for (n = 0; n < 64 && !(o_s_bvalid && i_s_bready); n++)
      @(negedge i_sys_clk);
    @(posedge i_sys_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e,
                    input logic chk, output logic [31:0] q);
    int n;
    @(posedge i_sys_clk);
    i_s_arvalid <= 1'b1;
    i_s_araddr  <= a;
    rq.push_back({chk, e});
    @(negedge i_sys_clk);
    for (n = 0; n < 64 && !o_s_arready; n++) @(negedge i_sys_clk);
    `CHK("arready", 1'b1, o_s_arready)
    @(posedge i_sys_clk);
    i_s_arvalid <= 1'b0;
    @(negedge i_sys_clk);
    for (n = 0; n < 64 && !(o_s_rvalid && i_s_rready); n++)
      @(negedge i_sys_clk);
    q = o_s_rdata;
    @(posedge i_sys_clk);
  endtask : rd

  // host polls until complete shows, never relaunching before that
  task automatic run_wait(output logic [31:0] q);
    int n;
    q = 32'h0000_0000;
    for (n = 0; n < 100 && q[1] !== 1'b1; n++)
      rd(`AKC_OFF_CTRL, 34'h0, 1'b0, q);
  endtask : run_wait

  task automatic end_of_test();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #(50 * 20000);
    bad_count++;
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    rd(`AKC_OFF_CTRL, {2'h0, 32'h0000_0004}, 1'b1, d);
    foreach (OFFS[i]) rd(OFFS[i], 34'h0, 1'b1, d);
    foreach (OFFS[i]) begin
      v[i] = $random(seed);
      wr(OFFS[i], v[i], 4'hF, `AKC_RESP_OKAY);
      rd(OFFS[i], {`AKC_RESP_OKAY, v[i]}, 1'b1, d);
    end
    `CHK("frame", v[0], o_frame_count)
    `CHK("param addr", {v[1], v[3]}, o_param_addr)
    `CHK("in addr", {v[4], v[5]}, o_in_addr)
    `CHK("out addr", {v[4], v[6]}, o_out_addr)
    `CHK("in step", v[7], o_in_step)
    `CHK("out step", v[8], o_out_step)
    wr(`AKC_OFF_FRAME, 32'hA5A5_A5A5, 4'h5, `AKC_RESP_OKAY);
    v[0] = {v[0][31:24], 8'hA5, v[0][15:8], 8'hA5};
    rd(`AKC_OFF_FRAME, {2'h0, v[0]}, 1'b1, d);
    // enable low must hold off the bus answer and the register alike
    i_ce <= 1'b0;
    fork
      wr(`AKC_OFF_FRAME, 32'h0F1E_2D3C, 4'hF, `AKC_RESP_OKAY);
      begin
        repeat (6) @(negedge i_sys_clk);
        `CHK("frozen awready", 1'b0, o_s_awready)
        `CHK("frozen frame", v[0], o_frame_count)
        @(posedge i_sys_clk);
        i_ce <= 1'b1;
      end
    join
    v[0] = 32'h0F1E_2D3C;
    `CHK("frame after freeze", v[0], o_frame_count)
    wr(8'h40, 32'hFFFF_FFFF, 4'hF, `AKC_RESP_SLVERR);
    rd(8'h40, {`AKC_RESP_SLVERR, 32'h0}, 1'b1, d);
    rd(`AKC_OFF_SRST, 34'h0, 1'b1, d);
    wr(`AKC_OFF_CTRL, 32'hFFFF_FF7E, 4'hF, `AKC_RESP_OKAY);
    rd(`AKC_OFF_CTRL, {2'h0, 32'h0000_0004}, 1'b1, d);
    // two jobs back to back, the second from a new instruction base
    for (int j = 0; j < 2; j++) begin
      base = {v[1], v[2]};
      wr(`AKC_OFF_CTRL, 32'h0000_0001, 4'hF, `AKC_RESP_OKAY);
      run_wait(d);
      `CHK("ctrl done", 32'h0000_0006, d)
      rd(`AKC_OFF_CTRL, {2'h0, 32'h0000_0004}, 1'b1, d);
      v[2] = $random(seed);
      wr(`AKC_OFF_INS_LO, v[2], 4'hF, `AKC_RESP_OKAY);
    end
    base = {v[1], v[2]};
    wr(`AKC_OFF_CTRL, 32'h0000_0081, 4'hF, `AKC_RESP_OKAY);
    run_wait(d);
    `CHK("auto launch", 2'b11, {d[7], d[0]})
    wr(`AKC_OFF_CTRL, 32'h0000_0000, 4'hF, `AKC_RESP_OKAY);
    n0 = krst_n;
    wr(`AKC_OFF_SRST, 32'h0000_0001, 4'hF, `AKC_RESP_OKAY);
    `CHK("kernel reset", n0 + 1, krst_n)
    rd(`AKC_OFF_CTRL, {2'h0, 32'h0000_0004}, 1'b1, d);
    // configuration survives the kernel reset
    rd(`AKC_OFF_FRAME, {2'h0, v[0]}, 1'b1, d);
    repeat (4) @(posedge i_sys_clk);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
